// [hw/cfg_compare.sv]
/*
 Compares lane 0 alignment octets with the programmed copy and checks
 the received checksum against one computed from received data only.
 Assumes octets arrive in index order 0..13, checksum in octet 13.
*/
`timescale 1ns/1ps
module cfg_compare
	import link_irq_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	cfg_compare_if.cmp cmp
);
	logic diff_reg;
	logic [DATA_W-1:0] sum_reg;
	logic pulse_reg;
	logic cks_reg;
	logic [DATA_W-1:0] exp_octet;
	logic differs;
	logic [DATA_W-1:0] sum_next;

	always_comb begin
		exp_octet = cmp.expected[cmp.rx_index*DATA_W +: DATA_W];
		// Every octet, checksum included, takes part
		differs = cmp.rx_valid && (exp_octet != cmp.rx_octet);
		sum_next = (cmp.rx_index == OCT_IDX_ZERO) ? REG_RESET : sum_reg;
		if (cmp.rx_valid && cmp.rx_index != OCT_IDX_LAST)
			sum_next = DATA_W'(sum_next + cmp.rx_octet);
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			diff_reg <= 1'b0;
			sum_reg <= REG_RESET;
		end else if (cmp.rx_valid) begin
			diff_reg <= (cmp.rx_index == OCT_IDX_ZERO ? 1'b0 : diff_reg)
				| differs;
			sum_reg <= sum_next;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pulse_reg <= 1'b0;
			cks_reg <= 1'b0;
		end else begin
			pulse_reg <= cmp.rx_valid && cmp.rx_last && (differs ||
				(cmp.rx_index != OCT_IDX_ZERO && diff_reg));
			// Transmitted checksum against received sum only
			cks_reg <= cmp.rx_valid && cmp.rx_last &&
				(cmp.rx_octet == sum_reg);
		end
	end

	assign cmp.mismatch_pulse = pulse_reg;
	assign cmp.checksum_good_pulse = cks_reg;

	a_mismatch_on_diff: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(cmp.rx_valid && cmp.rx_last && differs) |=> cmp.mismatch_pulse)
		else $error("mismatch pulse missing");
	a_checksum_match: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(cmp.rx_valid && cmp.rx_last && cmp.rx_octet != sum_reg)
		|=> !cmp.checksum_good_pulse)
		else $error("checksum good without match");
endmodule // cfg_compare

// [hw/cfg_compare_if.sv]
/*
 Carrier between the register block and the alignment comparator.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
interface cfg_compare_if;
	import link_irq_pkg::*;
	logic [CFG_OCTETS*DATA_W-1:0] expected;
	logic rx_valid;
	logic [3:0] rx_index;
	logic [DATA_W-1:0] rx_octet;
	logic rx_last;
	logic mismatch_pulse;
	logic checksum_good_pulse;
	modport regs (output expected, output rx_valid, output rx_index,
		output rx_octet, output rx_last,
		input mismatch_pulse, input checksum_good_pulse);
	modport cmp (input expected, input rx_valid, input rx_index,
		input rx_octet, input rx_last,
		output mismatch_pulse, output checksum_good_pulse);
endinterface

// [hw/link_irq_pkg.sv]
/*
 Constants for the link interrupt status block: register offsets,
 field positions, reset values, alignment block size.
 Assumes nothing of its surroundings.
*/
package link_irq_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int CFG_OCTETS = 14;
	localparam logic [ADDR_W-1:0] CFG_BASE_ADDR = 12'h450;
	localparam logic [ADDR_W-1:0] CFG_LAST_ADDR = 12'h45D;
	localparam logic [ADDR_W-1:0] ENABLE_LOW_ADDR = 12'h4B8;
	localparam logic [ADDR_W-1:0] ENABLE_HIGH_ADDR = 12'h4B9;
	localparam logic [ADDR_W-1:0] STATUS_LOW_ADDR = 12'h4BA;
	localparam logic [ADDR_W-1:0] STATUS_HIGH_ADDR = 12'h4BB;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam int MISMATCH_BIT = 0;
	localparam int EV_DISPARITY = 7;
	localparam int EV_NOT_IN_TABLE = 6;
	localparam int EV_UNEXPECTED_K = 5;
	localparam int EV_DESKEW = 4;
	localparam int EV_LANE_SYNC = 3;
	localparam int EV_CHECKSUM = 2;
	localparam int EV_FRAME_SYNC = 1;
	localparam int EV_CODE_GROUP = 0;
	localparam logic [3:0] OCT_IDX_ZERO = 4'h0;
	localparam logic [3:0] OCT_IDX_LAST = 4'hD;
endpackage

// [hw/serial_link_irq_status.sv]
/*
 Link interrupt enable and status registers with the lane 0
 configuration mismatch check.
 Assumes the configuration port gives a one-cycle write or read strobe
 with address, and lane logic gives one-cycle event pulses.
*/
`timescale 1ns/1ps
// Overview of operation
// - Mismatch check looks at lane 0 octets only.
// - Received alignment data differing from programmed copy raises mismatch.
// - Every alignment octet, checksum included, is compared.
// - Low status bits 7..0: disparity, table, K, deskew, sync, cks, fs, cgs.
// - High status bit 0 is mismatch; bits 7..1 read zero.
// - Checksum event compares sent and computed sums, never programmed one.
module serial_link_irq_status
	import link_irq_pkg::*;
#(
	parameter int LANES = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [ADDR_W-1:0] cfg_addr_i,
	input wire logic [DATA_W-1:0] cfg_wdata_i,
	output logic [DATA_W-1:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	input wire logic [LANES-1:0] lane_valid_i,
	input wire logic [3:0] lane0_index_i,
	input wire logic [DATA_W-1:0] lane0_octet_i,
	input wire logic lane0_last_i,
	input wire logic [DATA_W-1:0] link_event_i,
	output logic irq_o
);
	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	logic [DATA_W-1:0] enable_low_reg;
	logic cfg_mismatch_enable;
	logic [DATA_W-1:0] status_low_reg;
	logic cfg_mismatch_flag;
	logic [DATA_W-1:0] cfg_copy_reg [CFG_OCTETS];
	logic [DATA_W-1:0] rdata_next;
	logic irq_reg;
	logic [DATA_W-1:0] event_vec;
	cfg_compare_if link ();

	function automatic logic hit(input logic [ADDR_W-1:0] a);
		return a == cfg_addr_i;
	endfunction

	function automatic logic in_cfg(input logic [ADDR_W-1:0] a);
		return a >= CFG_BASE_ADDR && a <= CFG_LAST_ADDR;
	endfunction

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			enable_low_reg <= REG_RESET;
			cfg_mismatch_enable <= 1'b0;
		end else if (cfg_wr_i) begin
			if (hit(ENABLE_LOW_ADDR))
				enable_low_reg <= cfg_wdata_i;
			if (hit(ENABLE_HIGH_ADDR))
				cfg_mismatch_enable <= cfg_wdata_i[MISMATCH_BIT];
		end
	end

	generate
		for (genvar i = 0; i < CFG_OCTETS; i++) begin : g_copy
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i)
					cfg_copy_reg[i] <= REG_RESET;
				else if (cfg_wr_i && hit(ADDR_W'(CFG_BASE_ADDR + i)))
					cfg_copy_reg[i] <= cfg_wdata_i;
			end
			assign link.expected[i*DATA_W +: DATA_W] = cfg_copy_reg[i];
		end
	endgenerate

	// ---------------------------------------------
	// Comparator hookup
	// ---------------------------------------------
	// Other lanes never reach the comparator
	assign link.rx_valid = lane_valid_i[0];
	assign link.rx_index = lane0_index_i;
	assign link.rx_octet = lane0_octet_i;
	assign link.rx_last = lane0_last_i;

	cfg_compare u_cmp (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.cmp(link.cmp)
	);

	// ---------------------------------------------
	// Sticky flags
	// ---------------------------------------------
	// Checksum event comes from the comparator, never from the pin
	always_comb begin
		event_vec = link_event_i;
		event_vec[EV_CHECKSUM] = link.checksum_good_pulse;
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			status_low_reg <= REG_RESET;
		end else begin
			for (int b = 0; b < DATA_W; b++) begin
				if (event_vec[b])
					status_low_reg[b] <= 1'b1;
				else if (cfg_wr_i && hit(STATUS_LOW_ADDR) &&
					cfg_wdata_i[b])
					status_low_reg[b] <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			cfg_mismatch_flag <= 1'b0;
		else if (link.mismatch_pulse)
			cfg_mismatch_flag <= 1'b1;
		else if (cfg_wr_i && hit(STATUS_HIGH_ADDR) &&
			cfg_wdata_i[MISMATCH_BIT])
			cfg_mismatch_flag <= 1'b0;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(status_low_reg & enable_low_reg) ||
				(cfg_mismatch_flag && cfg_mismatch_enable);
	end
	assign irq_o = irq_reg;

	// ---------------------------------------------
	// Read path
	// ---------------------------------------------
	always_comb begin
		rdata_next = REG_RESET;
		if (hit(ENABLE_LOW_ADDR))
			rdata_next = enable_low_reg;
		else if (hit(ENABLE_HIGH_ADDR))
			rdata_next[MISMATCH_BIT] = cfg_mismatch_enable;
		else if (hit(STATUS_LOW_ADDR))
			rdata_next = status_low_reg;
		else if (hit(STATUS_HIGH_ADDR))
			rdata_next[MISMATCH_BIT] = cfg_mismatch_flag;
		else if (in_cfg(cfg_addr_i))
			rdata_next = cfg_copy_reg[4'(cfg_addr_i - CFG_BASE_ADDR)];
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cfg_rdata_o <= REG_RESET;
			cfg_rvalid_o <= 1'b0;
		end else begin
			cfg_rvalid_o <= cfg_rd_i;
			if (cfg_rd_i)
				cfg_rdata_o <= rdata_next;
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	sequence s_flag_enabled;
		(status_low_reg & enable_low_reg) != REG_RESET;
	endsequence

	// Last lane 0 octet that differs from the programmed copy
	sequence s_last_octet_differs;
		lane_valid_i[0] && lane0_last_i &&
			lane0_octet_i != cfg_copy_reg[OCT_IDX_LAST];
	endsequence

	// Comparator pulse first, sticky flag on the following edge
	sequence s_pulse_then_flag;
		link.mismatch_pulse ##1 cfg_mismatch_flag;
	endsequence

	// A clear that no new mismatch overrides
	sequence s_clear_mismatch;
		cfg_wr_i && hit(STATUS_HIGH_ADDR) && cfg_wdata_i[MISMATCH_BIT] &&
			!link.mismatch_pulse;
	endsequence

	a_irq_follows_flag: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) s_flag_enabled |=> irq_o)
		else $error("irq not raised");
	a_irq_needs_cause: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		irq_o |-> $past(|(status_low_reg & enable_low_reg) ||
			(cfg_mismatch_flag && cfg_mismatch_enable)))
		else $error("irq without cause");
	a_event_sets_flag: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		link_event_i[EV_DISPARITY] |=> status_low_reg[EV_DISPARITY])
		else $error("event flag not set");
	a_high_reserved_zero: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(cfg_rd_i && hit(STATUS_HIGH_ADDR)) |=>
			cfg_rdata_o[DATA_W-1:1] == 7'h00)
		else $error("reserved bits nonzero");
	a_mismatch_sets: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		link.mismatch_pulse |=> cfg_mismatch_flag)
		else $error("mismatch flag not set");
	a_lane0_only: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		!lane_valid_i[0] |=> !link.mismatch_pulse)
		else $error("mismatch from other lane");
	a_full_compare: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_last_octet_differs |=> s_pulse_then_flag)
		else $error("checksum octet not compared");
	a_write_clears: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_clear_mismatch |=> !cfg_mismatch_flag)
		else $error("write one did not clear");
	a_checksum_sets: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		link.checksum_good_pulse |=> status_low_reg[EV_CHECKSUM])
		else $error("checksum flag not set");
	a_checksum_pin_ignored: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(!link.checksum_good_pulse && !status_low_reg[EV_CHECKSUM])
		|=> !status_low_reg[EV_CHECKSUM])
		else $error("checksum flag set from pin");
endmodule // serial_link_irq_status

// [verif/lane_tx_model.sv]
/*
 Transmitter model for the lanes: sends one 14-octet alignment block.
 Assumes the receiver samples on rising edges of core_clk_i.
*/
`timescale 1ns/1ps
module lane_tx_model (
	input wire logic core_clk_i,
	input wire logic start_i,
	input wire logic [1:0] mode_i,
	output logic [7:0] lane_valid_o,
	output logic [3:0] index_o,
	output logic [7:0] octet_o,
	output logic last_o,
	output logic busy_o
);
	initial begin
		lane_valid_o = 8'h00;
		index_o = 4'hF;
		octet_o = 8'h5A;
		last_o = 1'b0;
		busy_o = 1'b0;
	end
	// Mode 1 spoils the checksum, mode 2 sends on lane 1 only
	task automatic send();
		logic [7:0] sum;
		sum = 8'h00;
		busy_o <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			lane_valid_o <= (mode_i == 2'h2) ? 8'h02 : 8'h01;
			index_o <= 4'(i);
			octet_o <= (i == 13) ? sum ^ {7'h00, mode_i == 2'h1}
				: 8'h10 + 8'(i);
			last_o <= (i == 13);
			sum = sum + 8'h10 + 8'(i);
			@(posedge core_clk_i);
		end
		// Released lines change, so a stale octet cannot pass
		lane_valid_o <= 8'h00;
		index_o <= ~index_o;
		octet_o <= ~octet_o;
		last_o <= 1'b0;
		busy_o <= 1'b0;
	endtask
	always @(posedge core_clk_i) begin
		if (start_i) begin
			send();
		end
	end
endmodule // lane_tx_model

// [verif/serial_link_irq_status_tb_top.sv]
/*
 Testbench: register tasks, event pulses and lane 0 blocks.
 Assumes a single 20 MHz clock and the lane_tx_model partner.
*/
`timescale 1ns/1ps
module serial_link_irq_status_tb_top;
	import link_irq_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic start = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] ev = 8'h00;
	logic [7:0] rdata, lv, oct;
	logic [3:0] idx;
	logic rvalid, last, irq, busy;
	int failures = 0;
	int tests_run = 0;
	initial begin
		forever #25 clk = ~clk;
	end
	serial_link_irq_status serial_link_irq_status_i (
		.core_clk_i(clk), .rst_n_i(rst_n), .cfg_wr_i(wr_s),
		.cfg_rd_i(rd_s), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
		.cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .lane_valid_i(lv),
		.lane0_index_i(idx), .lane0_octet_i(oct), .lane0_last_i(last),
		.link_event_i(ev), .irq_o(irq));
	lane_tx_model lane_tx_model_i (
		.core_clk_i(clk), .start_i(start), .mode_i(mode),
		.lane_valid_o(lv), .index_o(idx), .octet_o(oct),
		.last_o(last), .busy_o(busy));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input string n, input logic [11:0] a, logic [7:0] e);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		// Answer stands for exactly the cycle after the strobe
		chk("rvalid", 8'h01, {7'h00, rvalid});
		chk(n, e, rdata);
		@(posedge clk);
		#1;
		chk("rvalid_end", 8'h00, {7'h00, rvalid});
	endtask
	task automatic irq_is(input logic e);
		@(posedge clk);
		#1;
		chk("irq", {7'h00, e}, {7'h00, irq});
	endtask
	// Waits for the block, then one edge for the flags and one for irq_o
	task automatic send(input logic [1:0] m);
		int k;
		k = 0;
		@(posedge clk);
		start <= 1'b1;
		mode <= m;
		@(posedge clk);
		start <= 1'b0;
		#1;
		while (busy !== 1'b0 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("busy", 8'h00, {7'h00, busy});
		repeat (2) @(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#(50 * 20000);
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd("rst", ENABLE_LOW_ADDR + 12'(i), REG_RESET);
		end
		rd("unmapped", 12'h7FF, 8'h00);
		wr(ENABLE_HIGH_ADDR, 8'hFF);
		rd("en_hi", ENABLE_HIGH_ADDR, 8'h01);
		$display("test registers finished");
		@(posedge clk);
		ev <= 8'hFF;
		@(posedge clk);
		ev <= 8'h00;
		rd("st_lo", STATUS_LOW_ADDR, 8'hFB);
		irq_is(1'b0);
		wr(ENABLE_LOW_ADDR, 8'h80);
		irq_is(1'b1);
		wr(STATUS_LOW_ADDR, 8'hFB);
		irq_is(1'b0);
		rd("st_lo", STATUS_LOW_ADDR, 8'h00);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= STATUS_LOW_ADDR;
		wdata <= 8'h80;
		ev <= 8'h80;
		@(posedge clk);
		wr_s <= 1'b0;
		ev <= 8'h00;
		rd("set_wins", STATUS_LOW_ADDR, 8'h80);
		wr(STATUS_LOW_ADDR, 8'h80);
		rd("cleared", STATUS_LOW_ADDR, 8'h00);
		$display("test events finished");
		for (int i = 0; i < 14; i++) begin
			wr(CFG_BASE_ADDR + 12'(i),
				(i == 13) ? 8'h1E : 8'h10 + 8'(i));
		end
		rd("cfg", CFG_LAST_ADDR, 8'h1E);
		wr(CFG_BASE_ADDR + 12'h003, 8'h55);
		send(2'h2);
		rd("lane1", STATUS_HIGH_ADDR, 8'h00);
		send(2'h0);
		rd("st_hi", STATUS_HIGH_ADDR, 8'h01);
		rd("st_lo", STATUS_LOW_ADDR, 8'h04);
		irq_is(1'b1);
		wr(STATUS_HIGH_ADDR, 8'h01);
		irq_is(1'b0);
		wr(CFG_BASE_ADDR + 12'h003, 8'h13);
		send(2'h0);
		rd("st_hi", STATUS_HIGH_ADDR, 8'h00);
		wr(STATUS_LOW_ADDR, 8'h04);
		wr(CFG_LAST_ADDR, 8'h00);
		send(2'h0);
		rd("cks_cfg", STATUS_HIGH_ADDR, 8'h01);
		rd("cks_ok", STATUS_LOW_ADDR, 8'h04);
		wr(STATUS_HIGH_ADDR, 8'h01);
		wr(STATUS_LOW_ADDR, 8'h04);
		wr(CFG_LAST_ADDR, 8'h1E);
		send(2'h1);
		rd("cks_bad", STATUS_HIGH_ADDR, 8'h01);
		rd("cks_bad", STATUS_LOW_ADDR, 8'h00);
		irq_is(1'b1);
		wr(ENABLE_HIGH_ADDR, 8'h00);
		irq_is(1'b0);
		$display("test alignment finished");
		report_and_stop();
	end
endmodule // serial_link_irq_status_tb_top
